// file: core/eucfg_defs.vh
// constants for the extension unit strap configuration block
`ifndef EUCFG_DEFS_VH
`define EUCFG_DEFS_VH
`define EUCFG_CLK_HZ 20000000
`define EUCFG_FILTER_US 1500
`define EUCFG_FILTER_CYC 21'h0_7530
`define EUCFG_POWERUP_MS 200
`define EUCFG_POWERUP_CYC (`EUCFG_POWERUP_MS * (`EUCFG_CLK_HZ / 1000))
`define EUCFG_WIN_BYTES 16
`define EUCFG_SLOT_BITS 8
`define EUCFG_RANGE0_LO 8'h00
`define EUCFG_RANGE1_LO 8'h10
`define EUCFG_RANGE2_LO 8'h20
`define EUCFG_RANGE3_LO 8'h30
`define EUCFG_RANGE_FULL_SPAN 8'h0F
`define EUCFG_RANGE_SHORT_SPAN 8'h0B
`define EUCFG_RANGE3_HI 8'h3C
`define EUCFG_HUNDREDS 8'h64
`define EUCFG_ROLE_NONE 2'h0
`define EUCFG_ROLE_PRI 2'h1
`define EUCFG_ROLE_SEC 2'h2
`define EUCFG_ROLE_TER 2'h3
`define EUCFG_STS_SPARE0 0
`define EUCFG_STS_SPARE1 1
`define EUCFG_STS_DEFCTL 2
`endif

// file: core/eucfg_sync.v
// two flip-flop synchroniser for a vector of asynchronous strap and pin levels, the interface pulse included
`timescale 1ns/100ps
module eucfg_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire srst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: core/eucfg_top.v
// strap decoding, slot range match and group interrupt filter
`timescale 1ns/100ps
`include "eucfg_defs.vh"
module eucfg_top #(
  parameter POWERUP_CYC = `EUCFG_POWERUP_CYC
) (
  input wire clk_sys,
  input wire srst,
  input wire reset_release_strap,
  input wire [1:0] unit_number_high_strap,
  input wire [1:0] unit_number_low_strap,
  input wire [1:0] range_extension_strap,
  input wire [1:0] slot_range0_strap,
  input wire [1:0] slot_range1_strap,
  input wire [1:0] slot_range2_strap,
  input wire [1:0] slot_range3_strap,
  input wire [1:0] spare_strap,
  input wire default_control_strap,
  input wire filter_strap,
  input wire [2:0] irq_resp_strap_ch1,
  input wire [2:0] irq_resp_strap_ch2,
  input wire [1:0] zero_substitution_strap,
  input wire [1:0] force_sync_strap,
  input wire [1:0] force_master_strap,
  input wire [1:0] inhibit_sync_strap,
  input wire [1:0] inhibit_master_strap,
  input wire [1:0] master_only_bus_strap,
  input wire [1:0] mismatch_inhibit_strap,
  input wire [1:0] alt_decode_strap,
  input wire [1:0] group_interrupt_line_n,
  input wire interface_clock_pulse,
  input wire [1:0] sync_in,
  input wire [1:0] channel_master_signal_in,
  input wire [1:0] channel_mismatch_fault_in,
  input wire [7:0] slot_addr,
  input wire area_second,
  input wire [5:0] irq_addr,
  input wire substitute_active,
  input wire [7:0] redundant_module_data,
  output reg unit_reset,
  output reg unit_active,
  output reg [1:0] unit_number_ch1,
  output reg [1:0] unit_number_ch2,
  output reg [5:0] reg_window_base,
  output reg reg_window_hit,
  output reg slot_hit,
  output reg [7:0] slot_full_number,
  output reg [4:0] range_strap_status,
  output reg control_taken,
  output reg [2:0] status_straps,
  output reg group_interrupt_out,
  output reg [5:0] irq_resp_ch1,
  output reg [5:0] irq_resp_ch2,
  output reg [2:0] irq_resp_status,
  output reg [7:0] substitute_data,
  output reg zero_substitution_status,
  output reg [1:0] sync_out,
  output reg [1:0] channel_master_signal,
  output reg [1:0] bus_enable,
  output reg [1:0] channel_mismatch_fault,
  output reg [1:0] alt_decode
);
  localparam [20:0] FILT_CYC = `EUCFG_FILTER_CYC;
  localparam [31:0] PWR_CYC = POWERUP_CYC;

  // straps and pins are all asynchronous levels
  wire [32:1] strap_raw;
  wire [32:1] strap_s;
  assign strap_raw = {unit_number_high_strap, unit_number_low_strap,
    range_extension_strap, slot_range0_strap, slot_range1_strap,
    slot_range2_strap, slot_range3_strap, spare_strap,
    default_control_strap, filter_strap, irq_resp_strap_ch1,
    irq_resp_strap_ch2, zero_substitution_strap, force_sync_strap,
    force_master_strap, inhibit_sync_strap};
  eucfg_sync #(.W(32)) u_strap_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(strap_raw),
    .q(strap_s)
  );

  wire [7:0] pin_raw;
  wire [7:0] pin_s;
  assign pin_raw = {reset_release_strap, group_interrupt_line_n,
    interface_clock_pulse, sync_in, channel_master_signal_in};
  eucfg_sync #(.W(8)) u_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(pin_raw),
    .q(pin_s)
  );
  wire [1:0] fault_s;
  eucfg_sync #(.W(2)) u_fault_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(channel_mismatch_fault_in),
    .q(fault_s)
  );

  wire [1:0] s_unh = strap_s[32:31];
  wire [1:0] s_unl = strap_s[30:29];
  wire [1:0] s_range_extension_strap = strap_s[28:27];
  wire [1:0] s_pe0 = strap_s[26:25];
  wire [1:0] s_pe1 = strap_s[24:23];
  wire [1:0] s_pe2 = strap_s[22:21];
  wire [1:0] s_pe3 = strap_s[20:19];
  wire [1:0] s_spare = strap_s[18:17];
  wire s_defctl = strap_s[16];
  wire s_filter = strap_s[15];
  wire [2:0] s_ir1 = strap_s[14:12];
  wire [2:0] s_ir2 = strap_s[11:9];
  wire [1:0] s_zsub = strap_s[8:7];
  wire [1:0] s_fsync = strap_s[6:5];
  wire [1:0] s_fmast = strap_s[4:3];
  wire [1:0] s_isync = strap_s[2:1];
  wire p_release = pin_s[7];
  wire [1:0] p_irq_n = pin_s[6:5];
  wire p_tclk = pin_s[4];
  wire [1:0] p_sync = pin_s[3:2];
  wire [1:0] p_mast = pin_s[1:0];

  // per-channel strap copies kept separate on purpose: a mismatch shows as
  // differing channel behaviour, which is how the cpus detect it
  wire [1:0] s_monly = master_only_bus_strap;
  wire [1:0] s_minh = mismatch_inhibit_strap;
  wire [1:0] s_alt = alt_decode_strap;
  reg [1:0] monly_reg;
  reg [1:0] monly_meta_reg;
  reg [1:0] minh_reg;
  reg [1:0] minh_meta_reg;
  reg [1:0] alt_reg;
  reg [1:0] alt_meta_reg;
  reg [1:0] imast_meta_reg;
  reg [1:0] imast_reg;
  always @(posedge clk_sys) begin
    if (srst) begin
      monly_meta_reg <= 2'h3;
      monly_reg <= 2'h3;
      minh_meta_reg <= 2'h3;
      minh_reg <= 2'h3;
      alt_meta_reg <= 2'h3;
      alt_reg <= 2'h3;
      imast_meta_reg <= 2'h3;
      imast_reg <= 2'h3;
    end else begin
      monly_meta_reg <= s_monly;
      monly_reg <= monly_meta_reg;
      minh_meta_reg <= s_minh;
      minh_reg <= minh_meta_reg;
      alt_meta_reg <= s_alt;
      alt_reg <= alt_meta_reg;
      imast_meta_reg <= inhibit_master_strap;
      imast_reg <= imast_meta_reg;
    end
  end

  // power-up hold: reset stays while the release strap is open
  reg [31:0] pwr_cnt_reg;
  wire held = srst | p_release;
  always @(posedge clk_sys) begin
    if (held) begin
      pwr_cnt_reg <= 32'h0000_0000;
      unit_reset <= 1'b1;
      unit_active <= 1'b0;
    end else if (pwr_cnt_reg < PWR_CYC - 32'h0000_0001) begin
      pwr_cnt_reg <= pwr_cnt_reg + 32'h0000_0001;
      unit_reset <= 1'b1;
      unit_active <= 1'b0;
    end else begin
      unit_reset <= 1'b0;
      unit_active <= 1'b1;
    end
  end
  wire run = unit_active;

  // static configuration decode
  wire [1:0] num1 = {s_unh[0], s_unl[0]};
  wire [1:0] num2 = {s_unh[1], s_unl[1]};
  wire [7:0] span = s_range_extension_strap[0] ? `EUCFG_RANGE_SHORT_SPAN : `EUCFG_RANGE_FULL_SPAN;
  wire [7:0] hund = area_second ? `EUCFG_HUNDREDS : 8'h00;
  wire [7:0] rel = slot_addr - hund;
  wire in_area = area_second ? (slot_addr >= `EUCFG_HUNDREDS) : (slot_addr < `EUCFG_HUNDREDS);
  reg hit_c;
  always @* begin
    hit_c = 1'b0;
    if (!in_area) begin
      hit_c = 1'b0;
    end else if (!s_pe0[0] && rel >= `EUCFG_RANGE0_LO && rel <= `EUCFG_RANGE0_LO + span) begin
      hit_c = 1'b1;
    end else if (!s_pe1[0] && rel >= `EUCFG_RANGE1_LO && rel <= `EUCFG_RANGE1_LO + span) begin
      hit_c = 1'b1;
    end else if (!s_pe2[0] && rel >= `EUCFG_RANGE2_LO && rel <= `EUCFG_RANGE2_LO + span) begin
      hit_c = 1'b1;
    end else if (!s_pe3[0] && rel >= `EUCFG_RANGE3_LO && rel <= `EUCFG_RANGE3_HI) begin
      hit_c = 1'b1;
    end
  end

  // responsibility roles: {g2,g1,g0} two bits each
  function [5:0] eucfg_roles;
    input [2:0] st;
    reg [2:0] t;
    begin
      t = ~st;
      case (t)
        3'b001: eucfg_roles = {`EUCFG_ROLE_TER, `EUCFG_ROLE_SEC, `EUCFG_ROLE_PRI};
        3'b010: eucfg_roles = {`EUCFG_ROLE_SEC, `EUCFG_ROLE_PRI, `EUCFG_ROLE_TER};
        3'b100: eucfg_roles = {`EUCFG_ROLE_PRI, `EUCFG_ROLE_TER, `EUCFG_ROLE_SEC};
        3'b011: eucfg_roles = {`EUCFG_ROLE_SEC, `EUCFG_ROLE_PRI, `EUCFG_ROLE_PRI};
        3'b101: eucfg_roles = {`EUCFG_ROLE_PRI, `EUCFG_ROLE_SEC, `EUCFG_ROLE_PRI};
        3'b110: eucfg_roles = {`EUCFG_ROLE_PRI, `EUCFG_ROLE_PRI, `EUCFG_ROLE_SEC};
        3'b111: eucfg_roles = {`EUCFG_ROLE_PRI, `EUCFG_ROLE_PRI, `EUCFG_ROLE_PRI};
        default: eucfg_roles = 6'h00;
      endcase
    end
  endfunction

  reg control_reg;
  always @(posedge clk_sys) begin
    if (!run) begin
      unit_number_ch1 <= 2'h0;
      unit_number_ch2 <= 2'h0;
      reg_window_base <= 6'h00;
      reg_window_hit <= 1'b0;
      slot_hit <= 1'b0;
      slot_full_number <= 8'h00;
      range_strap_status <= 5'h00;
      status_straps <= 3'h0;
      irq_resp_ch1 <= 6'h00;
      irq_resp_ch2 <= 6'h00;
      irq_resp_status <= 3'h0;
      zero_substitution_status <= 1'b0;
      substitute_data <= 8'h00;
      control_reg <= 1'b0;
      control_taken <= 1'b0;
    end else begin
      unit_number_ch1 <= num1;
      unit_number_ch2 <= num2;
      reg_window_base <= {num1, 4'h0};
      reg_window_hit <= (irq_addr[5:4] == num1);
      slot_hit <= hit_c;
      slot_full_number <= rel;
      range_strap_status <= ~{s_range_extension_strap[0], s_pe3[0], s_pe2[0], s_pe1[0], s_pe0[0]};
      status_straps[`EUCFG_STS_SPARE0] <= s_spare[0];
      status_straps[`EUCFG_STS_SPARE1] <= s_spare[1];
      status_straps[`EUCFG_STS_DEFCTL] <= s_defctl;
      irq_resp_ch1 <= eucfg_roles(s_ir1);
      irq_resp_ch2 <= eucfg_roles(s_ir2);
      irq_resp_status <= ~s_ir1;
      zero_substitution_status <= ~s_zsub[0];
      if (substitute_active) begin
        substitute_data <= s_zsub[0] ? 8'h00 : redundant_module_data;
      end
      // control decided once when the unit leaves reset
      if (!control_reg) begin
        control_reg <= 1'b1;
        control_taken <= s_defctl;
      end
    end
  end

  // group interrupt: sampled on interface pulse, then optional filter
  reg tclk_d_reg;
  reg irq_sync_reg;
  reg [20:0] filt_cnt_reg;
  reg filt_busy_reg;
  wire tick = p_tclk & ~tclk_d_reg;
  wire irq_now = ~p_irq_n[0];
  always @(posedge clk_sys) begin
    if (!run) begin
      // track the pulse while held, so release shows no false edge
      tclk_d_reg <= p_tclk;
      irq_sync_reg <= 1'b0;
      filt_cnt_reg <= 21'h00_0000;
      filt_busy_reg <= 1'b0;
      group_interrupt_out <= 1'b0;
    end else begin
      tclk_d_reg <= p_tclk;
      if (tick) begin
        irq_sync_reg <= irq_now;
      end
      if (s_filter) begin
        group_interrupt_out <= irq_sync_reg;
        filt_busy_reg <= 1'b0;
        filt_cnt_reg <= 21'h00_0000;
      end else if (filt_busy_reg) begin
        // the line must stay quiet for a whole window before re-arming,
        // so redundant late edges fold into the first event
        if (irq_sync_reg) begin
          filt_cnt_reg <= 21'h00_0000;
        end else if (filt_cnt_reg >= FILT_CYC - 21'h00_0001) begin
          filt_busy_reg <= 1'b0;
          group_interrupt_out <= 1'b0;
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 21'h00_0001;
        end
      end else if (irq_sync_reg) begin
        if (filt_cnt_reg >= FILT_CYC - 21'h00_0001) begin
          group_interrupt_out <= 1'b1;
          filt_busy_reg <= 1'b1;
          filt_cnt_reg <= 21'h00_0000;
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 21'h00_0001;
        end
      end else begin
        filt_cnt_reg <= 21'h00_0000;
      end
    end
  end

  // service overrides, all straps open in normal use; the bus gate follows
  // the overridden master so a forced master still reaches the adapter
  wire [1:0] mast_eff = (p_mast | ~s_fmast) & imast_reg;
  always @(posedge clk_sys) begin
    if (!run) begin
      sync_out <= 2'h0;
      channel_master_signal <= 2'h0;
      bus_enable <= 2'h0;
      channel_mismatch_fault <= 2'h0;
      alt_decode <= 2'h0;
    end else begin
      sync_out <= (p_sync | ~s_fsync) & s_isync;
      channel_master_signal <= mast_eff;
      bus_enable <= monly_reg | mast_eff;
      channel_mismatch_fault <= fault_s & minh_reg;
      alt_decode <= ~alt_reg;
    end
  end
endmodule

// file: dv/eucfg_properties.sv
// port assertions for the strap configuration block
`timescale 1ns/100ps
module eucfg_checker (
  input wire clk_sys, srst, reset_release_strap, default_control_strap, filter_strap,
  input wire unit_active, unit_reset, control_taken, group_interrupt_out, reg_window_hit,
  input wire [1:0] unit_number_high_strap, unit_number_low_strap, range_extension_strap,
  input wire [1:0] slot_range0_strap, slot_range1_strap, slot_range2_strap, slot_range3_strap,
  input wire [1:0] zero_substitution_strap, inhibit_sync_strap, master_only_bus_strap,
  input wire [1:0] group_interrupt_line_n, sync_out, channel_master_signal, bus_enable,
  input wire [1:0] unit_number_ch1,
  input wire [5:0] irq_addr, reg_window_base,
  input wire [4:0] range_strap_status,
  input wire [7:0] substitute_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire [1:0] un = {unit_number_high_strap[0], unit_number_low_strap[0]};
  wire [4:0] rs = ~{range_extension_strap[0], slot_range3_strap[0], slot_range2_strap[0],
    slot_range1_strap[0], slot_range0_strap[0]};
  held_in_reset_a: assert property (
    reset_release_strap [*4] |-> unit_reset && !unit_active)
    else $error("unit active with release strap open");
  unit_number_a: assert property (
    (unit_active && $stable(un)) [*4] |-> unit_number_ch1 == un)
    else $error("unit number wrong");
  window_base_a: assert property (
    (unit_active && $stable(un)) [*5] |-> reg_window_base == {un, 4'h0})
    else $error("window base wrong");
  window_hit_a: assert property (
    (unit_active && $stable(un)) [*5] |-> reg_window_hit == ($past(irq_addr[5:4]) == un))
    else $error("window hit wrong");
  range_status_a: assert property (
    (unit_active && $stable(rs)) [*4] |-> range_strap_status == rs)
    else $error("range status wrong");
  subst_zero_a: assert property (
    (unit_active && zero_substitution_strap[0]) [*4] |-> substitute_data == 8'h00)
    else $error("substitute data not zero");
  sync_inhibit_a: assert property (
    (unit_active && !inhibit_sync_strap[0]) [*4] |-> !sync_out[0])
    else $error("sync not inhibited");
  bus_gate_a: assert property (
    (unit_active && !master_only_bus_strap[0] && !channel_master_signal[0]) [*4] |->
    !bus_enable[0])
    else $error("bus enabled while not master");
  control_after_a: assert property (
    $rose(unit_active) |-> ##2 control_taken == default_control_strap)
    else $error("control after reset wrong");
  irq_direct_a: assert property (
    (unit_active && filter_strap && group_interrupt_line_n[0]) [*8] |-> !group_interrupt_out)
    else $error("interrupt out without input");
  irq_filter_a: assert property (
    $rose(group_interrupt_out) && !filter_strap |-> !$past(group_interrupt_line_n[0], 200))
    else $error("filtered interrupt too early");
  merge_window_a: assert property (
    $fell(group_interrupt_out) && !filter_strap |-> $past(group_interrupt_line_n[0], 200))
    else $error("filtered interrupt dropped early");
  cover property ($rose(unit_active));
  cover property ($rose(group_interrupt_out) && !filter_strap);
  cover property (unit_active && !bus_enable[0]);
endmodule
bind eucfg_top eucfg_checker u_chk (.*);

// file: dv/eucfg_cpu_side.sv
// cpu bus side model: interface pulse and per-channel levels
`timescale 1ns/100ps
module eucfg_cpu_side (
  input wire master_sel,
  input wire sync_req,
  input wire fault_req,
  output logic interface_clock_pulse,
  output wire [1:0] sync_in,
  output wire [1:0] channel_master_signal_in,
  output wire [1:0] channel_mismatch_fault_in
);
  // free running, phase unrelated to clk_sys
  initial interface_clock_pulse = 1'b0;
  always #60 interface_clock_pulse = ~interface_clock_pulse;
  // both cpus drive identical copies, one holds mastership
  assign sync_in = {2{sync_req}};
  assign channel_master_signal_in = master_sel ? 2'h2 : 2'h1;
  assign channel_mismatch_fault_in = {2{fault_req}};
endmodule

// file: dv/tb_top.sv
// self-checking bench for the strap configuration block
`timescale 1ns/100ps
module tb_top;
  localparam int PU = 20;
  logic clk_sys = 1'b0, srst = 1'b1, reset_release_strap = 1'b1, default_control_strap = 1'b1;
  logic filter_strap = 1'b1, area_second = 1'b0, substitute_active = 1'b0;
  logic master_sel = 1'b0, sync_req = 1'b0, fault_req = 1'b0;
  logic [1:0] unit_number_high_strap = 2'h0, unit_number_low_strap = 2'h0;
  logic [1:0] range_extension_strap = 2'h0, slot_range0_strap = 2'h3, slot_range1_strap = 2'h3;
  logic [1:0] slot_range2_strap = 2'h3, slot_range3_strap = 2'h3, spare_strap = 2'h3;
  logic [1:0] zero_substitution_strap = 2'h3, force_sync_strap = 2'h3, force_master_strap = 2'h3;
  logic [1:0] inhibit_sync_strap = 2'h3, inhibit_master_strap = 2'h3, alt_decode_strap = 2'h3;
  logic [1:0] master_only_bus_strap = 2'h3, mismatch_inhibit_strap = 2'h3;
  logic [1:0] group_interrupt_line_n = 2'h3;
  logic [2:0] irq_resp_strap_ch1 = 3'h7, irq_resp_strap_ch2 = 3'h7;
  logic [7:0] slot_addr = 8'h00, redundant_module_data = 8'h00;
  logic [5:0] irq_addr = 6'h00;
  wire interface_clock_pulse, unit_reset, unit_active, reg_window_hit, slot_hit, control_taken;
  wire group_interrupt_out, zero_substitution_status;
  wire [1:0] sync_in, channel_master_signal_in, channel_mismatch_fault_in, unit_number_ch1;
  wire [1:0] unit_number_ch2, sync_out, channel_master_signal, bus_enable, alt_decode;
  wire [1:0] channel_mismatch_fault;
  wire [5:0] reg_window_base, irq_resp_ch1, irq_resp_ch2;
  wire [4:0] range_strap_status;
  wire [2:0] status_straps, irq_resp_status;
  wire [7:0] slot_full_number, substitute_data;
  int error_cnt = 0, compares = 0, k;
  logic [5:0] rtab [8] = '{6'h15, 6'h16, 6'h19, 6'h1e, 6'h25, 6'h27, 6'h39, 6'h00};
  eucfg_top #(.POWERUP_CYC(PU)) u_dut (.*);
  eucfg_cpu_side u_cpu (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
    compares++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rst;
    srst = 1'b1;
    wt(2);
    srst = 1'b0;
    for (k = 0; k < PU + 20 && unit_active !== 1'b1; k++) wt(1);
    wt(2);
  endtask
  task automatic rng(input logic e, input logic [3:0] m, input logic [7:0] s, input logic a,
    input logic x);
    range_extension_strap = {2{e}};
    {slot_range3_strap, slot_range2_strap, slot_range1_strap, slot_range0_strap} =
      {{2{~m[3]}}, {2{~m[2]}}, {2{~m[1]}}, {2{~m[0]}}};
    slot_addr = s;
    area_second = a;
    wt(5);
    chk("slot_hit", x, slot_hit);
    chk("range_status", {3'h0, ~e, m}, range_strap_status);
    chk("slot_num", a ? s - 8'h64 : s, slot_full_number);
  endtask
  initial begin
    #(80000 * 50);
    error_cnt++;
    close_out;
  end
  initial begin
    wt(2);
    srst = 1'b0;
    wt(PU + 20);
    chk("held_reset", 1, unit_reset);
    chk("held_active", 0, unit_active);
    reset_release_strap = 1'b0;
    for (k = 0; k < PU + 20 && unit_active !== 1'b1; k++) wt(1);
    chk("powerup_wait", 1, k >= PU);
    chk("active", 1, unit_active);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      {unit_number_high_strap, unit_number_low_strap} = {{2{i[1]}}, {2{i[0]}}};
      irq_addr = {i[1:0], 4'h5};
      wt(5);
      chk("unit_ch1", i, unit_number_ch1);
      chk("unit_ch2", i, unit_number_ch2);
      chk("win_base", i * 16, reg_window_base);
      chk("win_hit", 1, reg_window_hit);
      irq_addr = {~i[1:0], 4'h5};
      wt(2);
      chk("win_miss", 0, reg_window_hit);
    end
    $display("test unit number done");
    rng(0, 4'h1, 8'h0f, 0, 1);
    rng(0, 4'h1, 8'h10, 0, 0);
    rng(1, 4'h1, 8'h0b, 0, 1);
    rng(1, 4'h1, 8'h0c, 0, 0);
    rng(1, 4'h2, 8'h1b, 0, 1);
    rng(1, 4'h2, 8'h1c, 0, 0);
    rng(1, 4'h4, 8'h2b, 0, 1);
    rng(1, 4'h4, 8'h2c, 0, 0);
    rng(1, 4'h8, 8'h3c, 0, 1);
    rng(1, 4'h8, 8'h3d, 0, 0);
    rng(0, 4'h2, 8'h74, 1, 1);
    rng(0, 4'h2, 8'h74, 0, 0);
    $display("test slot ranges done");
    for (int s = 0; s < 8; s++) begin
      irq_resp_strap_ch1 = s[2:0];
      irq_resp_strap_ch2 = s[2:0];
      wt(5);
      chk("resp_ch1", rtab[s], irq_resp_ch1);
      chk("resp_ch2", rtab[s], irq_resp_ch2);
      chk("resp_status", s[2:0] ^ 3'h7, irq_resp_status);
    end
    irq_resp_strap_ch1 = 3'h6;
    irq_resp_strap_ch2 = 3'h6;
    substitute_active = 1'b1;
    redundant_module_data = 8'ha5;
    zero_substitution_strap = 2'h0;
    spare_strap = 2'h2;
    wt(5);
    chk("subst_data", 8'ha5, substitute_data);
    chk("subst_status", 1, zero_substitution_status);
    chk("status", 3'h6, status_straps);
    zero_substitution_strap = 2'h1;
    wt(5);
    chk("subst_zero", 8'h00, substitute_data);
    chk("subst_status", 0, zero_substitution_status);
    $display("test interrupt roles done");
    sync_req = 1'b1;
    {inhibit_sync_strap, force_sync_strap} = 4'h0;
    wt(5);
    chk("sync_inh", 0, sync_out[0]);
    inhibit_sync_strap = 2'h3;
    sync_req = 1'b0;
    wt(5);
    chk("sync_force", 1, sync_out[0]);
    master_sel = 1'b1;
    force_master_strap = 2'h0;
    wt(5);
    chk("mast_force", 1, channel_master_signal[0]);
    inhibit_master_strap = 2'h0;
    master_sel = 1'b0;
    master_only_bus_strap = 2'h0;
    wt(5);
    chk("mast_inh", 0, channel_master_signal[0]);
    chk("bus_gated", 0, bus_enable[0]);
    {inhibit_master_strap, force_master_strap} = 4'hf;
    wt(5);
    chk("bus_master", 1, bus_enable[0]);
    fault_req = 1'b1;
    {mismatch_inhibit_strap, alt_decode_strap} = 4'h0;
    wt(5);
    chk("fault_inh", 0, channel_mismatch_fault[0]);
    chk("alt_dec", 2'h3, alt_decode);
    mismatch_inhibit_strap = 2'h3;
    wt(5);
    chk("fault_pass", 1, channel_mismatch_fault[0]);
    $display("test service straps done");
    default_control_strap = 1'b0;
    rst;
    chk("no_control", 0, control_taken);
    default_control_strap = 1'b1;
    rst;
    chk("control", 1, control_taken);
    $display("test control done");
    group_interrupt_line_n = 2'h2;
    for (k = 0; k < 20 && group_interrupt_out !== 1'b1; k++) wt(1);
    chk("irq_direct", 1, group_interrupt_out);
    group_interrupt_line_n = 2'h3;
    wt(20);
    chk("irq_clear", 0, group_interrupt_out);
    filter_strap = 1'b0;
    wt(5);
    group_interrupt_line_n = 2'h2;
    wt(200);
    chk("irq_delay", 0, group_interrupt_out);
    for (k = 200; k < 30300 && group_interrupt_out !== 1'b1; k++) wt(1);
    chk("irq_filt", 1, group_interrupt_out);
    chk("filt_time", 1, k >= 29900);
    group_interrupt_line_n = 2'h3;
    wt(200);
    // redundant late copy inside the window must not add a second event
    group_interrupt_line_n = 2'h2;
    wt(10);
    group_interrupt_line_n = 2'h3;
    chk("irq_merge", 1, group_interrupt_out);
    for (k = 0; k < 30300 && group_interrupt_out !== 1'b0; k++) wt(1);
    chk("irq_quiet", 0, group_interrupt_out);
    $display("test interrupt filter done");
    close_out;
  end
endmodule
